// ### lf_spi_regs.svh
// Purpose: constants for the serial command port
// Assumes: included by the package and the design file
// Notes:   command codes are 8-bit bytes; CMD_RD_WORK_HI is a 2-bit prefix
`ifndef LF_SPI_REGS_SVH
`define LF_SPI_REGS_SVH
`define CMD_CLASS_BIT      7
`define CMD_TXDATA_BIT     6
`define CMD_START_TX       8'hF0
`define CMD_SDO_ECHO       8'hF1
`define CMD_SDO_STATUS     8'hF2
`define CMD_SDO_GFAIL      8'hF3
`define CMD_SLEEP          8'hF8
`define CMD_STANDBY        8'hF9
`define CMD_SIG_STRENGTH   8'h38
`define CMD_PTR_RESET      8'h3B
`define CMD_DIAG           8'h3F
`define CMD_RD_WORK_HI     2'b10
`define BYTE_ONES          8'hFF
`define STATUS_BYTES       4'h7
`define MAX_DATA_BYTES     5'h0F
`define TIMEOUT_REF_CYCLES 32'h0000_30D4
`endif

// ### lf_spi_pkg.sv
// Purpose: shared types of the serial command port
// Assumes: lf_spi_regs.svh holds the numbers
// Notes:   none
`include "lf_spi_regs.svh"
package lf_spi_pkg;
  typedef enum logic [1:0] {
    SDO_STATUS = 2'b00,
    SDO_GFAIL  = 2'b01,
    SDO_ECHO   = 2'b10,
    SDO_WORK   = 2'b11
  } sdo_mode_t;

  // one decoded command handed to the core
  typedef struct packed {
    logic       circ_valid;
    logic       direct_valid;
    logic [7:0] code;
  } cmd_out_t;

  // error events raised by the port
  typedef struct packed {
    logic serial_err;
    logic unspec_cmd;
    logic overflow;
    logic timeout;
  } port_err_t;
endpackage : lf_spi_pkg

// ### lf_initiator_spi_command_port.sv
// Purpose: serial slave command port of an LF initiator
// Assumes: master-made link clock, sampled by sys_clk_i through two flops
// Notes:   the timeout counts ref_tick_i, one pulse per reference period
// Behaviour
// RULE1: deselected ignores clock, data; output released
// RULE2: master holds select low whole frame
// RULE3: sample on falling, drive on rising edge
// RULE4: command byte then zero to fifteen bytes
// RULE5: default output status bytes then ones
// RULE6: F3 sends general failure flag only
// RULE7: F1 echoes input one byte late
// RULE8: work register read from start address
// RULE9: partial last byte sets serial error
// RULE10: bit 7 circular or direct class
// RULE11: bit 6 loads transmit data bits
// RULE12: 0x codes load configuration register
// RULE13: 1x codes load immobilizer configuration
// RULE14: 2x codes load data format register
// RULE15: 30-37 load control register
// RULE16: 38 signal strength, 3B pointers, 3F diagnosis
// RULE17: F0 transmit, F8 sleep, F9 standby
// RULE18: timeout of 12500 reference periods
// RULE19: general failure flag inverted polarity
// RULE20: msb first; reserved codes flag unspecified
// RULE21: timeout discards frame and flags error
`include "lf_spi_regs.svh"
module lf_initiator_spi_command_port #(
  parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_REF_CYCLES
) (
  // clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   ref_tick_i,
  // serial pins
  input  wire logic                   select_n_i,
  input  wire logic                   sclk_i,
  input  wire logic                   sdi_i,
  output logic                        sdo_o,
  output logic                        sdo_oe_o,
  // status bytes from the core; byte 0 is the general status byte
  input  wire logic [7:0]             status_byte_i [7],
  input  wire logic                   gen_fail_n_i,
  // working register read port
  output logic [5:0]                  work_addr_o,
  input  wire logic [7:0]             work_data_i,
  // decoded commands and data to the core
  output lf_spi_pkg::cmd_out_t        cmd_o,
  output logic                        data_valid_o,
  output logic [7:0]                  data_o,
  input  wire logic                   sleep_i,
  // error events, one-cycle pulses
  output lf_spi_pkg::port_err_t       err_o
);
  import lf_spi_pkg::*;

  // two-flop synchronisers; stage one read only by stage two
  logic [2:0] sync1, sync2;
  logic       sel_d, sclk_d;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync1  <= 3'b010;                              // idle levels: select high, link clock low
      sync2  <= 3'b010;
      sel_d  <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      sync1  <= {sdi_i, select_n_i, sclk_i};
      sync2  <= sync1;
      sel_d  <= sync2[1];
      sclk_d <= sync2[0];
    end
  end

  logic sdi_s, sel_n, sclk_fall, sclk_rise, frame_end, frame_start;
  assign sdi_s       = sync2[2];
  assign sel_n       = sync2[1];
  assign sclk_fall   = ~sel_n & sclk_d & ~sync2[0];  // see RULE1 see RULE3
  assign sclk_rise   = ~sel_n & ~sclk_d & sync2[0];  // see RULE3
  assign frame_end   = sel_n & ~sel_d;               // see RULE9
  assign frame_start = ~sel_n & sel_d;

  // byte length of a circular command, zero for no data
  function automatic logic [4:0] data_len(input logic [7:0] c);
    logic [4:0] n;
    n = 5'h00;
    if (c[`CMD_TXDATA_BIT])
      n = 5'({2'b00, c[5:3]} + 5'h01);              // see RULE11: bits up to 64 in bytes
    else if (!c[5])
      n = 5'({1'b0, c[3:0]} + 5'h01);               // see RULE12 see RULE13
    else if (c[5:3] == 3'b100 || c[5:3] == 3'b101)
      n = 5'({2'b00, c[2:0]} + 5'h01);              // see RULE14
    else if (c[5:3] == 3'b110)
      n = 5'({2'b00, c[2:0]} + 5'h01);              // see RULE15
    return n;
  endfunction : data_len

  // reserved or unknown codes
  function automatic logic is_reserved(input logic [7:0] c);
    logic r;
    r = 1'b0;
    if (c[`CMD_CLASS_BIT])
      r = (c > `CMD_SDO_GFAIL) && (c != `CMD_SLEEP) && (c != `CMD_STANDBY); // see RULE17
    else if (!c[`CMD_TXDATA_BIT] && c[5:3] == 3'b111)
      r = (c != `CMD_SIG_STRENGTH) && (c != `CMD_PTR_RESET) && (c != `CMD_DIAG); // see RULE16
    if (c[7:6] == 2'b11 && c[5] == 1'b0)
      r = 1'b1;
    return r;
  endfunction : is_reserved

  // frame state
  logic [2:0]  bit_cnt, next_bit_cnt;
  logic [7:0]  shreg, next_shreg;
  logic [3:0]  byte_idx, next_byte_idx;
  logic [4:0]  remain, next_remain;
  logic        first, next_first;
  logic        dirty, next_dirty;
  logic        direct_frame, next_direct_frame;
  logic [7:0]  direct_code, next_direct_code;
  sdo_mode_t   mode, next_mode, frame_mode, next_frame_mode;
  logic [5:0]  waddr, next_waddr;
  logic [7:0]  outsh, next_outsh;
  logic [7:0]  echo, next_echo;
  logic        sdo, next_sdo;
  logic [31:0] tmo, next_tmo;
  cmd_out_t    cmd, next_cmd;
  logic        dv, next_dv;
  logic [7:0]  dat, next_dat;
  port_err_t   err, next_err;
  logic [7:0]  rx_byte;
  logic        byte_done;

  assign rx_byte   = {shreg[6:0], sdi_s};                   // see RULE20: msb first
  assign byte_done = sclk_fall && bit_cnt == 3'h7;

  // output byte for the given position of the frame
  function automatic logic [7:0] tx_byte(input sdo_mode_t m, input logic [3:0] i,
                                         input logic [7:0] e, input logic [7:0] w,
                                         input logic [7:0] s, input logic g);
    logic [7:0] b;
    b = `BYTE_ONES;
    case (m)
      SDO_STATUS: b = (i < `STATUS_BYTES) ? s : `BYTE_ONES;  // see RULE5
      SDO_GFAIL:  b = {7'h7F, g};                            // see RULE6 see RULE19
      SDO_ECHO:   b = (i == 4'h0) ? `BYTE_ONES : e;          // see RULE7
      SDO_WORK:   b = w;                                     // see RULE8
      default:    b = `BYTE_ONES;
    endcase
    return b;
  endfunction : tx_byte

  // next values of the frame logic
  always_comb begin
    next_bit_cnt      = bit_cnt;
    next_shreg        = shreg;
    next_byte_idx     = byte_idx;
    next_remain       = remain;
    next_first        = first;
    next_dirty        = dirty;
    next_direct_frame = direct_frame;
    next_direct_code  = direct_code;
    next_mode         = mode;
    next_frame_mode   = frame_mode;
    next_waddr        = waddr;
    next_outsh        = outsh;
    next_echo         = echo;
    next_sdo          = sdo;
    next_tmo          = tmo;
    next_cmd          = '0;
    next_dv           = 1'b0;
    next_dat          = dat;
    next_err          = '0;
    if (sel_n) begin
      next_tmo = '0;
    end else if (ref_tick_i && tmo < TIMEOUT_CYCLES) begin
      next_tmo = tmo + 32'h0000_0001;                        // see RULE18
    end
    if (frame_start) begin
      next_bit_cnt      = 3'h0;
      next_byte_idx     = 4'h0;
      next_first        = 1'b1;
      next_dirty        = 1'b0;
      next_direct_frame = 1'b0;
      next_remain       = 5'h00;
      next_frame_mode   = mode;
      next_outsh        = tx_byte(mode, 4'h0, `BYTE_ONES, work_data_i, status_byte_i[0], gen_fail_n_i);
      next_sdo          = next_outsh[7];
    end else if (!sel_n && tmo == TIMEOUT_CYCLES) begin
      if (!dirty) next_err.timeout = 1'b1;                   // see RULE21: report once
      next_dirty        = 1'b1;
      next_direct_frame = 1'b0;
    end else if (sclk_fall) begin
      next_shreg   = rx_byte;
      next_bit_cnt = 3'(bit_cnt + 3'h1);
      if (byte_done && !dirty) begin
        next_echo     = rx_byte;
        next_byte_idx = (byte_idx == 4'hF) ? byte_idx : 4'(byte_idx + 4'h1);
        if (frame_mode == SDO_WORK) next_waddr = 6'(waddr + 6'h01);
        if (direct_frame) begin
          next_err.unspec_cmd = 1'b1;                        // see RULE10: direct needs own frame
          next_direct_frame   = 1'b0;
          next_dirty          = 1'b1;
        end else if (remain != 5'h00) begin
          next_dv     = 1'b1;
          next_dat    = rx_byte;
          next_remain = 5'(remain - 5'h01);
        end else if (rx_byte[`CMD_CLASS_BIT] && first) begin
          next_direct_frame = 1'b1;                          // see RULE10
          next_direct_code  = rx_byte;
        end else if (rx_byte[`CMD_CLASS_BIT]) begin
          next_err.unspec_cmd = 1'b1;
        end else if (is_reserved(rx_byte)) begin
          next_err.unspec_cmd = 1'b1;                        // see RULE20
        end else begin
          next_cmd.circ_valid = 1'b1;                        // see RULE10 see RULE16
          next_cmd.code       = rx_byte;
          next_remain         = data_len(rx_byte);
          if (data_len(rx_byte) > `MAX_DATA_BYTES) next_err.overflow = 1'b1; // see RULE4
        end
        next_first = 1'b0;
      end
    end else if (sclk_rise && bit_cnt == 3'h0) begin
      // every byte, the first too, reloads here so its msb stands through the first sample
      next_outsh = tx_byte(frame_mode, byte_idx, echo, work_data_i, status_byte_i[byte_idx[2:0]], gen_fail_n_i);
      next_sdo   = next_outsh[7];                            // see RULE3
    end else if (sclk_rise) begin
      next_outsh = {outsh[6:0], 1'b1};
      next_sdo   = outsh[6];
    end
    if (frame_end) begin
      if (bit_cnt != 3'h0) next_err.serial_err = 1'b1;       // see RULE9
      if (direct_frame && bit_cnt == 3'h0 && !dirty) begin
        next_cmd.direct_valid = 1'b1;                        // see RULE17
        next_cmd.code         = direct_code;
        case (direct_code)
          `CMD_SDO_ECHO:   next_mode = SDO_ECHO;
          `CMD_SDO_STATUS: next_mode = SDO_STATUS;
          `CMD_SDO_GFAIL:  next_mode = SDO_GFAIL;
          `CMD_SLEEP:      next_mode = SDO_STATUS;
          default:         next_mode = (mode == SDO_GFAIL) ? SDO_GFAIL : SDO_STATUS;
        endcase
        if (is_reserved(direct_code)) begin
          next_cmd.direct_valid = 1'b0;
          next_err.unspec_cmd   = 1'b1;
        end
      end else if (frame_mode == SDO_ECHO || frame_mode == SDO_WORK) begin
        next_mode = SDO_STATUS;                              // one-frame modes end here
      end
      if (direct_frame && !dirty && direct_code[7:6] == `CMD_RD_WORK_HI
          && bit_cnt == 3'h0 && byte_idx == 4'h1) begin
        next_mode  = SDO_WORK;                               // see RULE8
        next_waddr = direct_code[5:0];
      end
    end
    if (sleep_i && mode == SDO_GFAIL) next_mode = SDO_STATUS; // see RULE6
  end

  // register stage
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bit_cnt <= 3'h0; shreg <= 8'h00; byte_idx <= 4'h0; remain <= 5'h00;
      first <= 1'b1; dirty <= 1'b0; direct_frame <= 1'b0; direct_code <= 8'h00;
      mode <= SDO_STATUS; frame_mode <= SDO_STATUS; waddr <= 6'h00;
      outsh <= `BYTE_ONES; echo <= `BYTE_ONES; sdo <= 1'b1; tmo <= '0;
      cmd <= '0; dv <= 1'b0; dat <= 8'h00; err <= '0;
    end else begin
      bit_cnt <= next_bit_cnt; shreg <= next_shreg; byte_idx <= next_byte_idx;
      remain <= next_remain; first <= next_first; dirty <= next_dirty;
      direct_frame <= next_direct_frame; direct_code <= next_direct_code;
      mode <= next_mode; frame_mode <= next_frame_mode; waddr <= next_waddr;
      outsh <= next_outsh; echo <= next_echo; sdo <= next_sdo; tmo <= next_tmo;
      cmd <= next_cmd; dv <= next_dv; dat <= next_dat; err <= next_err;
    end
  end

  // read-register mode records its address on the frame that carried it
  assign work_addr_o  = waddr;
  assign sdo_o        = sdo;
  assign sdo_oe_o     = ~sel_n;                              // see RULE1
  assign cmd_o        = cmd;
  assign data_valid_o = dv;
  assign data_o       = dat;
  assign err_o        = err;

  // no circular or data strobe may follow a cycle in which the port was deselected
  sequence s_quiet;
    !cmd_o.circ_valid && !data_valid_o;
  endsequence
  property p_release;
    @(posedge sys_clk_i) disable iff (rst_i) sel_n |-> !sdo_oe_o ##1 s_quiet;
  endproperty
  a_release: assert property (p_release) else $error("port active while deselected"); // see RULE1

  property p_partial;
    @(posedge sys_clk_i) disable iff (rst_i) (frame_end && bit_cnt != 3'h0) |=> err_o.serial_err;
  endproperty
  a_partial: assert property (p_partial) else $error("partial byte not flagged"); // see RULE9

  sequence s_one_pulse;
    err_o.timeout ##1 !err_o.timeout;
  endsequence
  property p_timeout;
    @(posedge sys_clk_i) disable iff (rst_i) (!sel_n && !frame_start && tmo == TIMEOUT_CYCLES && !dirty)
      |=> s_one_pulse;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not reported once"); // see RULE21

  property p_idle_tmo;
    @(posedge sys_clk_i) disable iff (rst_i) sel_n |=> tmo == '0;
  endproperty
  a_idle_tmo: assert property (p_idle_tmo) else $error("timeout runs while idle"); // see RULE18

  property p_gfail;
    @(posedge sys_clk_i) disable iff (rst_i) (frame_start && mode == SDO_GFAIL) |=> outsh[7:1] == 7'h7F;
  endproperty
  a_gfail: assert property (p_gfail) else $error("failure byte has low bits"); // see RULE6

  property p_status;
    @(posedge sys_clk_i) disable iff (rst_i) (frame_start && mode == SDO_STATUS)
      |=> outsh == $past(status_byte_i[0]);
  endproperty
  a_status: assert property (p_status) else $error("status byte not first"); // see RULE5

  property p_sdir;
    @(posedge sys_clk_i) disable iff (rst_i) (byte_done && first && !dirty && rx_byte[7])
      |=> direct_frame && !cmd_o.circ_valid;
  endproperty
  a_sdir: assert property (p_sdir) else $error("direct command treated as circular"); // see RULE10

  property p_circ;
    @(posedge sys_clk_i) disable iff (rst_i) cmd_o.circ_valid |-> !cmd_o.code[7];
  endproperty
  a_circ: assert property (p_circ) else $error("circular strobe with direct code"); // see RULE10
endmodule : lf_initiator_spi_command_port

// ### lf_spi_host_model.sv
// Purpose: serial bus master model that faces the command port
// Assumes: sys_clk_i is the 40 ns bench clock; link clock is 8 cycles
// Notes:   link clock idles low; the released data line toggles
module lf_spi_host_model (
  // clock
  input  wire logic sys_clk_i,
  // serial pins
  output logic      select_n_o,
  output logic      sclk_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy = 1'b0;

  initial begin
    select_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end

  // between frames the data line changes every cycle, so a stale bit never looks valid
  always @(posedge sys_clk_i) begin
    if (!busy) sdi_o <= ~sdi_o;
  end

  // one frame: select held low throughout, bits msb first, then a hold before release
  task automatic xfer(input logic [7:0] tx [16], input int nbits, input int hold, output logic [7:0] rx [16]);
    busy = 1'b1;
    @(posedge sys_clk_i) select_n_o <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    for (int i = 0; i < nbits; i++) begin
      repeat (4) @(posedge sys_clk_i);
      sclk_o <= 1'b1;
      sdi_o  <= tx[i / 8][7 - i % 8]; // changes with the rise, holds past the fall
      repeat (4) @(posedge sys_clk_i);
      sclk_o <= 1'b0;
      rx[i / 8][7 - i % 8] = sdo_i;
    end
    repeat (hold + 4) @(posedge sys_clk_i);
    select_n_o <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    busy = 1'b0;
  endtask : xfer
endmodule : lf_spi_host_model

// ### lf_initiator_spi_command_port_test.sv
// Purpose: self-checking bench for the serial command port
// Assumes: timeout shortened to 200 reference ticks
// Notes:   output events are noted in a queue and matched in order
module lf_initiator_spi_command_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  import lf_spi_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ref_tick = 1'b0;
  logic        select_n, sclk, sdi, sdo, sdo_oe, data_valid;
  logic        gen_fail_n = 1'b1;
  logic        sleep = 1'b0;
  logic [7:0]  stat [7];
  logic [5:0]  work_addr;
  logic [7:0]  work_data, data;
  cmd_out_t    cmd;
  port_err_t   err;
  logic [22:0] ev;
  logic [22:0] q [$];
  logic [7:0]  cq [$];
  logic [7:0]  tx [16];
  logic [7:0]  rsv [15] = '{8'h39, 8'h3A, 8'h3C, 8'h3D, 8'h3E, 8'hF4, 8'hF5, 8'hF6, 8'hF7,
                            8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'hFE, 8'hFF};
  logic [15:0] seed = 16'hF8A2;
  logic [5:0]  base = 6'h00;
  int          mode = 0;
  int          n_errors = 0;
  int          total_checks = 0;
  int          tick_cnt = 0;
  wire         sdo_pin = sdo_oe ? sdo : 1'bz;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // data bytes that follow each circular code
  function automatic int nd(input logic [7:0] c);
    if (c[6]) return c[5:3] + 1;
    if (c[5:3] == 3'b111) return 0;
    if (c[5]) return c[2:0] + 1;
    return c[3:0] + 1;
  endfunction : nd

  initial forever #20 sys_clk_i = ~sys_clk_i;
  initial foreach (stat[i]) begin
    seed = lfsr(seed);
    stat[i] = seed[7:0];
  end
  // working register contents follow the address, so any slip shows up
  assign work_data = {work_addr, 2'b01};
  assign ev = {cmd.circ_valid, cmd.direct_valid, cmd.code & {8{cmd.circ_valid | cmd.direct_valid}},
               data_valid, data & {8{data_valid}}, err};

  // reference tick near 2 MHz
  always @(posedge sys_clk_i) begin
    tick_cnt <= (tick_cnt == 12) ? 0 : tick_cnt + 1;
    ref_tick <= (tick_cnt == 12);
  end

  lf_initiator_spi_command_port #(.TIMEOUT_CYCLES(200)) i_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ref_tick_i(ref_tick), .select_n_i(select_n), .sclk_i(sclk),
    .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .status_byte_i(stat), .gen_fail_n_i(gen_fail_n),
    .work_addr_o(work_addr), .work_data_i(work_data), .cmd_o(cmd), .data_valid_o(data_valid),
    .data_o(data), .sleep_i(sleep), .err_o(err));
  lf_spi_host_model i_host (.sys_clk_i(sys_clk_i), .select_n_o(select_n), .sclk_o(sclk), .sdi_o(sdi),
    .sdo_i(sdo_pin));

  task automatic check(input logic [22:0] seen, input logic [22:0] want);
    total_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("mismatch at %0t: seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic close_out();
    if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // any event with nothing noted is compared against zero and fails
  always @(posedge sys_clk_i) begin
    if (rst_i === 1'b0 && {cmd.circ_valid, cmd.direct_valid, data_valid, err} !== 7'h00)
      check(ev, (q.size() > 0) ? q.pop_front() : 23'h00_0000);
  end

  // one frame; the answer bytes depend on the output mode in force
  task automatic frame(input int nbits, input int hold, input bit cmp);
    logic [7:0] rx [16];
    logic [7:0] w;
    i_host.xfer(tx, nbits, hold, rx);
    for (int i = 0; i < nbits / 8; i++) begin
      case (mode)
        0: w = (i < 7) ? stat[i] : 8'hFF;
        1: w = {7'h7F, gen_fail_n};
        2: w = (i == 0) ? 8'hFF : tx[i - 1];
        default: w = {base + 6'(i), 2'b01};
      endcase
      if (cmp) check(rx[i], w);
    end
    if (mode > 1) mode = 0;
    check(sdo_oe, 1'b0);
  endtask : frame

  task automatic direct(input logic [7:0] c, input int m);
    tx[0] = c;
    q.push_back({2'b01, c, 13'h0000});
    frame(8, 0, 1);
    mode = m;
  endtask : direct

  // chain of circular codes, each followed by its nd count of random data bytes
  task automatic circ(input int extra, input logic [3:0] e);
    int n;
    n = 0;
    foreach (cq[j]) begin
      tx[n] = cq[j];
      n++;
      q.push_back({2'b10, cq[j], 13'h0000});
      repeat (nd(cq[j])) begin
        seed = lfsr(seed);
        tx[n] = seed[7:0];
        n++;
        q.push_back({10'h000, 1'b1, seed[7:0], 4'h0});
      end
    end
    if (e != 4'h0) q.push_back({19'h0_0000, e});
    frame(8 * n + extra, 0, 1);
  endtask : circ

  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    cq = '{8'h0E};
    circ(0, 4'h0);
    cq = '{8'h10, 8'h20, 8'h28, 8'h38, 8'h3B, 8'h3F, 8'h47, 8'h31};
    circ(0, 4'h0);
    foreach (rsv[i]) begin
      tx[0] = rsv[i];
      q.push_back({19'h0_0000, 4'b0100});
      frame(8, 0, 1);
    end
    tx[0] = 8'h0F;
    q.push_back({2'b10, 8'h0F, 9'h000, 4'b0010});
    frame(8, 0, 1);
    direct(8'hF0, 0);
    direct(8'hF8, 0);
    direct(8'hF9, 0);
    tx[0] = 8'hF0;
    tx[1] = 8'h00;
    q.push_back({19'h0_0000, 4'b0100});
    frame(16, 0, 1);
    direct(8'hF3, 1);
    @(posedge sys_clk_i) gen_fail_n <= 1'b0;
    cq = '{8'h20};
    circ(0, 4'h0);
    direct(8'hF2, 0);
    circ(0, 4'h0);
    direct(8'hF3, 1);
    @(posedge sys_clk_i) gen_fail_n <= 1'b1;
    circ(0, 4'h0);
    @(posedge sys_clk_i) sleep <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    sleep <= 1'b0;
    mode = 0;
    circ(0, 4'h0);
    direct(8'hF1, 2);
    cq = '{8'h01};
    circ(0, 4'h0);
    base = 6'h3E;
    direct(8'hBE, 3);
    circ(0, 4'h0);
    cq = '{8'h3B};
    circ(4, 4'b1000);
    tx[0] = 8'h30;
    q.push_back({2'b10, 8'h30, 13'h0000});
    q.push_back({19'h0_0000, 4'b0001});
    frame(8, 3000, 0);
    for (int i = 0; i < 500 && q.size() > 0; i++) @(posedge sys_clk_i);
    check(q.size(), 0);
    close_out();
  end

  // hang guard
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    n_errors++;
    close_out();
  end
endmodule : lf_initiator_spi_command_port_test
